// ==== shared/pla_pkg.sv ====
// Constants and types shared by the line acquisition and readout block.
// Assumes one clock domain at 125 MHz.
package pla_pkg;
  localparam int          PIXELS_PER_LINE   = 224;
  localparam int          LINES_PER_IMAGE   = 288;
  localparam int          PIXEL_BITS        = 8;
  localparam int          COL_BITS          = 8;
  localparam int          ROW_BITS          = 9;
  localparam int          BYTES_PER_LINE    = 225;
  localparam logic [7:0]  CYCLE_LIMIT       = 8'hFF;
  localparam logic [7:0]  FULL_SCALE        = 8'hFF;
  localparam logic [7:0]  LINE_TERM_BYTE    = 8'h00;
  localparam logic [7:0]  FILLER_BYTE       = 8'hFF;
  localparam logic [7:0]  LAST_COL          = 8'hDF;
  localparam logic [7:0]  TERM_COL          = 8'hE0;
  localparam logic [8:0]  LAST_ROW          = 9'h11F;
  localparam logic [2:0]  LAST_BIT          = 3'h7;
  localparam logic        MODE_PARALLEL     = 1'b1;
  localparam logic        MODE_SERIAL       = 1'b0;

  typedef logic [PIXEL_BITS-1:0] pixel_t;

  typedef enum logic [3:0] {
    ACQ_IDLE   = 4'b0001,
    ACQ_CHARGE = 4'b0010,
    ACQ_DRAIN  = 4'b0100,
    ACQ_DONE   = 4'b1000
  } acq_state_t;

  function automatic logic [7:0] nextCol(input logic [7:0] col);
    nextCol = (col == TERM_COL) ? 8'h00 : 8'(col + 8'h01);
  endfunction : nextCol
endpackage : pla_pkg

// ==== shared/line_mem_if.sv ====
// Write and read ports of the line memory between sequencer and memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface line_mem_if;
  import pla_pkg::*;
  logic       writeEn;
  logic [7:0] writeAddr;
  pla_pkg::pixel_t writeData;
  logic [7:0] readAddr;
  pla_pkg::pixel_t readData;
  modport ctrl (output writeEn, output writeAddr, output writeData, output readAddr,
                input readData);
  modport mem  (input writeEn, input writeAddr, input writeData, input readAddr,
                output readData);
endinterface : line_mem_if
`default_nettype wire

// ==== rtl/line_memory.sv ====
// Line storage: 224 bytes, registered read data.
// Assumes the sequencer serialises write and read addressing.
`timescale 1ns/1ps
`default_nettype none
module line_memory (
  input  wire logic ref_clk,
  input  wire logic clkEn,
  line_mem_if.mem   port
);
  import pla_pkg::*;
  pixel_t store [0:PIXELS_PER_LINE-1];

  always_ff @(posedge ref_clk) begin
    if (clkEn && port.writeEn) begin
      store[port.writeAddr] <= port.writeData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      port.readData <= store[port.readAddr];
    end
  end
endmodule : line_memory
`default_nettype wire

// ==== rtl/pixel_counter.sv ====
// One pixel's charge-cycle counter; count becomes the gray level.
// Assumes the comparator input is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pixel_counter (
  input  wire logic   ref_clk,
  input  wire logic   resetn,
  input  wire logic   clkEn,
  input  wire logic   start,
  input  wire logic   chargeTick,
  input  wire logic   cmpEqual,
  output logic        done,
  output pla_pkg::pixel_t gray
);
  import pla_pkg::*;
  logic [7:0] count;
  logic       running;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count   <= 8'h00;
      running <= 1'b0;
      done    <= 1'b0;
      gray    <= 8'h00;
    end else if (clkEn) begin
      if (start) begin
        count   <= 8'h00;
        running <= 1'b1;
        done    <= 1'b0;
      end else if (running && cmpEqual) begin
        gray    <= count;
        running <= 1'b0;
        done    <= 1'b1;
      end else if (running && chargeTick) begin
        if (count == CYCLE_LIMIT - 8'h01) begin
          gray    <= FULL_SCALE;
          running <= 1'b0;
          done    <= 1'b1;
        end
        count <= 8'(count + 8'h01);
      end
    end
  end
endmodule : pixel_counter
`default_nettype wire

// ==== rtl/pixel_line_acquire_readout.sv ====
// Line acquisition and byte readout sequencer of a 224 x 288 sensor array.
// Assumes comparator inputs and host strobes synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Image is 288 lines of 224 pixels, one 8-bit gray value each.
// - Each pixel alternates charge and discharge phases, at most 255 pairs.
// - An 8-bit counter counts charge cycles and its value on comparator match is the gray level.
// - All 224 pixels of a line are acquired in parallel in one pass.
// - Acquired values are first captured into a line holding register.
// - The held line is then copied into the output shift register.
// - Mode selects direct parallel output or the serializer.
// - Parallel mode presents whole bytes; serial mode shifts bits out.
// - The next line is acquired while the current one is shifted out.
// - Each line ends with one 00h byte, 225 bytes per line.
// - After the last line, groups of 224 FFh bytes plus 00h repeat.
// - Two selectable sensing dynamics set the comparator reference.
// - Readout goes line by line from the first line, byte by byte from the first pixel.
// - A pointer reset returns readout to the first pixel of the first line.
module pixel_line_acquire_readout (
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic          clkEn,
  input  wire logic          parallelMode,
  input  wire logic          highDynamics,
  input  wire logic          pointerReset,
  input  wire logic          byteRequest,
  input  wire logic [223:0]  cmpEqual,
  output logic               charge_switch,
  output logic               discharge_switch,
  output logic               refSelectHigh,
  output logic [7:0]         parallelData,
  output logic               parallelValid,
  output logic               serialData,
  output logic               serialValid,
  output logic               byteDone
);
  import pla_pkg::*;

  function automatic logic atTermCol(input logic [7:0] col);
    atTermCol = (col == TERM_COL);
  endfunction : atTermCol

  function automatic logic lastPixel(input logic [7:0] col);
    lastPixel = (col == LAST_COL);
  endfunction : lastPixel

  acq_state_t         acqState;
  logic               startPass;
  logic               chargeTick;
  logic [223:0]       pixDone;
  pixel_t             gray [0:PIXELS_PER_LINE-1];
  pixel_t             holdLine [0:PIXELS_PER_LINE-1];
  logic               holdFull;
  logic [7:0]         copyIdx;
  logic               copying;
  logic               shiftReady;
  logic [8:0]         acqRow;
  logic [8:0]         outRow;
  logic [7:0]         outCol;
  logic               imageDone;
  logic               fetchPending;
  logic [2:0]         bitIdx;
  logic [7:0]         serialShift;
  logic               serialBusy;
  logic [7:0]         curByte;
  logic               byteBusy;
  logic               emitReq;
  logic               lastCopy;

  line_mem_if lineBus ();

  // Output shift store, registered read
  line_memory u_mem (
    .ref_clk (ref_clk),
    .clkEn   (clkEn),
    .port    (lineBus.mem)
  );

  // One charge counter per column
  genvar g;
  generate
    for (g = 0; g < PIXELS_PER_LINE; g++) begin : gen_pix
      pixel_counter u_cnt (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .clkEn      (clkEn),
        .start      (startPass),
        .chargeTick (chargeTick),
        .cmpEqual   (cmpEqual[g] && !pixDone[g] && acqState == ACQ_DRAIN),
        .done       (pixDone[g]),
        .gray       (gray[g])
      );
    end
  endgenerate

  // Reference level follows dynamics setting
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      refSelectHigh <= 1'b1;
    end else if (clkEn) begin
      refSelectHigh <= highDynamics;
    end
  end

  // Charge/discharge sequencer, one pass per line
  assign startPass  = (acqState == ACQ_IDLE) && !holdFull && (acqRow <= LAST_ROW) && !pointerReset;
  assign chargeTick = (acqState == ACQ_CHARGE);
  assign lastCopy   = copying && lastPixel(copyIdx);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acqState         <= ACQ_IDLE;
      charge_switch    <= 1'b0;
      discharge_switch <= 1'b0;
    end else if (clkEn) begin
      case (acqState)
        ACQ_IDLE: begin
          charge_switch    <= 1'b0;
          discharge_switch <= 1'b0;
          if (startPass) begin
            acqState      <= ACQ_CHARGE;
            charge_switch <= 1'b1;
          end
        end
        ACQ_CHARGE: begin
          charge_switch    <= 1'b0;
          discharge_switch <= 1'b1;
          acqState         <= ACQ_DRAIN;
        end
        ACQ_DRAIN: begin
          discharge_switch <= 1'b0;
          if (&pixDone) begin
            acqState <= ACQ_DONE;
          end else begin
            charge_switch <= 1'b1;
            acqState      <= ACQ_CHARGE;
          end
        end
        ACQ_DONE: begin
          acqState <= ACQ_IDLE;
        end
        default: acqState <= ACQ_IDLE;
      endcase
      // Pointer reset aborts the pass
      if (pointerReset) begin
        acqState         <= ACQ_IDLE;
        charge_switch    <= 1'b0;
        discharge_switch <= 1'b0;
      end
    end
  end

  // Line holding register
  always_ff @(posedge ref_clk) begin
    if (clkEn && acqState == ACQ_DONE) begin
      for (int i = 0; i < PIXELS_PER_LINE; i++) begin
        holdLine[i] <= gray[i];
      end
    end
  end

  // Copy sequencing and line count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      holdFull <= 1'b0;
      acqRow   <= 9'h000;
      copying  <= 1'b0;
      copyIdx  <= 8'h00;
    end else if (clkEn) begin
      if (pointerReset) begin
        holdFull <= 1'b0;
        acqRow   <= 9'h000;
        copying  <= 1'b0;
        copyIdx  <= 8'h00;
      end else begin
        if (acqState == ACQ_DONE) begin
          holdFull <= 1'b1;
          acqRow   <= 9'(acqRow + 9'h001);
        end
        if (holdFull && !copying && !shiftReady) begin
          copying <= 1'b1;
          copyIdx <= 8'h00;
        end else if (copying) begin
          if (lastPixel(copyIdx)) begin
            copying  <= 1'b0;
            holdFull <= 1'b0;
          end
          copyIdx <= 8'(copyIdx + 8'h01);
        end
      end
    end
  end

  // Copy held line into the shift store, read out by column
  assign lineBus.writeEn   = copying;
  assign lineBus.writeAddr = copyIdx;
  assign lineBus.writeData = holdLine[copyIdx];
  assign lineBus.readAddr  = (outCol > LAST_COL) ? LAST_COL : outCol;

  // Output pointer and byte emission
  // No take while done shows, so a request held through done is used once
  assign emitReq = byteRequest && !byteDone && !byteBusy && !fetchPending
                   && !pointerReset
                   && (shiftReady || imageDone);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shiftReady   <= 1'b0;
      outRow       <= 9'h000;
      outCol       <= 8'h00;
      imageDone    <= 1'b0;
      fetchPending <= 1'b0;
      curByte      <= 8'h00;
    end else if (clkEn) begin
      if (pointerReset) begin
        shiftReady   <= 1'b0;
        outRow       <= 9'h000;
        outCol       <= 8'h00;
        imageDone    <= 1'b0;
        fetchPending <= 1'b0;
      end else begin
        if (lastCopy) begin
          shiftReady <= 1'b1;
        end
        if (emitReq) begin
          fetchPending <= 1'b1;
        end
        if (fetchPending) begin
          fetchPending <= 1'b0;
          if (atTermCol(outCol)) begin
            curByte <= LINE_TERM_BYTE;
          end else if (imageDone) begin
            curByte <= FILLER_BYTE;
          end else begin
            curByte <= lineBus.readData;
          end
          outCol <= nextCol(outCol);
          if (atTermCol(outCol) && !imageDone) begin
            shiftReady <= 1'b0;
            outRow     <= 9'(outRow + 9'h001);
            if (outRow == LAST_ROW) begin
              imageDone <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Byte presented on the selected path
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      byteBusy      <= 1'b0;
      parallelData  <= 8'h00;
      parallelValid <= 1'b0;
      serialShift   <= 8'h00;
      serialBusy    <= 1'b0;
      bitIdx        <= 3'h0;
      serialData    <= 1'b0;
      serialValid   <= 1'b0;
      byteDone      <= 1'b0;
    end else if (clkEn) begin
      parallelValid <= 1'b0;
      serialValid   <= 1'b0;
      byteDone      <= 1'b0;
      if (emitReq) begin
        byteBusy <= 1'b1;
      end
      if (byteBusy && !fetchPending && !serialBusy) begin
        if (parallelMode == MODE_PARALLEL) begin
          parallelData  <= curByte;
          parallelValid <= 1'b1;
          byteDone      <= 1'b1;
          byteBusy      <= 1'b0;
        end else begin
          serialShift <= curByte;
          serialBusy  <= 1'b1;
          bitIdx      <= 3'h0;
        end
      end
      // Serializer, MSB first
      if (serialBusy) begin
        serialData  <= serialShift[7];
        serialValid <= 1'b1;
        serialShift <= {serialShift[6:0], 1'b0};
        bitIdx      <= 3'(bitIdx + 3'h1);
        if (bitIdx == LAST_BIT) begin
          serialBusy <= 1'b0;
          byteBusy   <= 1'b0;
          byteDone   <= 1'b1;
        end
      end
      if (pointerReset) begin
        byteBusy   <= 1'b0;
        serialBusy <= 1'b0;
      end
    end
  end
endmodule : pixel_line_acquire_readout
`default_nettype wire

// ==== bench/readout_properties.sv ====
// Port timing checker for the readout block.
// Assumes binding onto pixel_line_acquire_readout.
`timescale 1ns/1ps
`default_nettype none
module readout_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic highDynamics,
  input wire logic pointerReset,
  input wire logic byteRequest,
  input wire logic charge_switch,
  input wire logic discharge_switch,
  input wire logic refSelectHigh,
  input wire logic parallelValid,
  input wire logic serialValid,
  input wire logic byteDone
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_switch_excl: assert property (!(charge_switch && discharge_switch))
    else $error("both switches closed");
  a_charge_drain: assert property (charge_switch && !pointerReset |=> discharge_switch)
    else $error("no discharge after charge");
  a_dyn_copy: assert property (refSelectHigh == $past(highDynamics))
    else $error("reference select not following dynamics");
  a_par_done: assert property (parallelValid |-> byteDone)
    else $error("parallel byte without done");
  a_par_pulse: assert property (parallelValid |=> !parallelValid)
    else $error("parallel valid too long");
  a_par_cause: assert property (parallelValid |-> $past(byteRequest, 3))
    else $error("parallel byte without request");
  a_ser_burst: assert property ($rose(serialValid) |-> serialValid[*8] ##1 !serialValid)
    else $error("serial burst not eight bits");
  a_ser_last: assert property ($rose(serialValid) |-> ##7 byteDone)
    else $error("serial done misplaced");
  a_one_path: assert property (!(parallelValid && serialValid))
    else $error("both output paths active");
  a_done_path: assert property (byteDone |-> parallelValid || serialValid)
    else $error("done without output");
  c_par: cover property (parallelValid);
  c_ser: cover property ($rose(serialValid));
  c_ptr: cover property (pointerReset);
endmodule : readout_checker
bind pixel_line_acquire_readout readout_checker chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .highDynamics(highDynamics),
  .pointerReset(pointerReset), .byteRequest(byteRequest),
  .charge_switch(charge_switch), .discharge_switch(discharge_switch),
  .refSelectHigh(refSelectHigh), .parallelValid(parallelValid),
  .serialValid(serialValid), .byteDone(byteDone)
);
`default_nettype wire

// ==== bench/host_reader.sv ====
// Host side model: requests bytes, gathers them from either path.
// Assumes lineStart pulses with the pointer reset.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        load,
  input  wire logic [15:0] count,
  input  wire logic        lineStart,
  input  wire logic [7:0]  parallelData,
  input  wire logic        parallelValid,
  input  wire logic        serialData,
  input  wire logic        serialValid,
  input  wire logic        byteDone,
  output logic             byteRequest,
  output logic             gotByte,
  output logic [7:0]       gotData,
  output logic             termMiss
);
  import pla_pkg::*;
  logic [15:0] left;
  logic [7:0]  shift;
  logic [7:0]  col;
  wire logic [7:0] rxByte = parallelValid ? parallelData : {shift[6:0], serialData};
  // Request held through each done until the done of the last counted byte
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      left        <= 16'h0000;
      byteRequest <= 1'b0;
    end else if (load) begin
      left        <= count;
      byteRequest <= 1'b1;
    end else if (byteDone && byteRequest) begin
      left        <= left - 16'h0001;
      byteRequest <= (left > 16'h0001);
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift <= 8'h00;
    end else if (serialValid) begin
      shift <= {shift[6:0], serialData};
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gotByte  <= 1'b0;
      gotData  <= 8'h00;
      col      <= 8'h00;
      termMiss <= 1'b0;
    end else begin
      gotByte <= byteDone;
      if (lineStart) begin
        col <= 8'h00;
      end else if (byteDone) begin
        gotData <= rxByte;
        col     <= nextCol(col);
        if (col == TERM_COL && rxByte != LINE_TERM_BYTE) termMiss <= 1'b1;
      end
    end
  end
endmodule : host_reader
`default_nettype wire

// ==== bench/pixel_line_acquire_readout_test.sv ====
// Self-checking bench for the readout block.
// Assumes the host model drives the byte request.
`timescale 1ns/1ps
`default_nettype none
module pixel_line_acquire_readout_test;
  import pla_pkg::*;
  logic         ref_clk      = 1'b0;
  logic         resetn       = 1'b0;
  logic         parallelMode = 1'b1;
  logic         highDynamics = 1'b1;
  logic         pointerReset = 1'b0;
  logic         load         = 1'b0;
  logic [15:0]  count        = 16'h0000;
  logic [223:0] cmpEqual     = '0;
  logic         byteRequest, charge_switch, discharge_switch, refSelectHigh;
  logic [7:0]   parallelData, gotData;
  logic         parallelValid, serialData, serialValid, byteDone, gotByte, termMiss;
  int           errors = 0;
  int           compares = 0;
  initial forever #4 ref_clk = ~ref_clk;
  pixel_line_acquire_readout dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .clkEn(1'b1), .parallelMode(parallelMode),
    .highDynamics(highDynamics), .pointerReset(pointerReset), .byteRequest(byteRequest),
    .cmpEqual(cmpEqual), .charge_switch(charge_switch), .discharge_switch(discharge_switch),
    .refSelectHigh(refSelectHigh), .parallelData(parallelData),
    .parallelValid(parallelValid), .serialData(serialData), .serialValid(serialValid),
    .byteDone(byteDone));
  host_reader host_u (
    .ref_clk(ref_clk), .resetn(resetn), .load(load), .count(count),
    .lineStart(pointerReset), .parallelData(parallelData), .parallelValid(parallelValid),
    .serialData(serialData), .serialValid(serialValid), .byteDone(byteDone),
    .byteRequest(byteRequest), .gotByte(gotByte), .gotData(gotData), .termMiss(termMiss));
  task check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task start_read(input int n);
    @(posedge ref_clk);
    count <= 16'(n);
    load  <= 1'b1;
    @(posedge ref_clk);
    load  <= 1'b0;
  endtask : start_read
  task get_byte(output logic [7:0] b);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (gotByte !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    check({7'h00, gotByte}, 8'h01);
    b = gotData;
  endtask : get_byte
  task t_reset;
    check(refSelectHigh, 8'h01);
    check({parallelValid, serialValid, byteDone}, 8'h00);
  endtask : t_reset
  task t_par_blank;
    logic [7:0] b;
    start_read(2 * BYTES_PER_LINE);
    for (int i = 0; i < 2 * BYTES_PER_LINE; i++) begin
      get_byte(b);
      check(b, (i % BYTES_PER_LINE == 224) ? LINE_TERM_BYTE : FULL_SCALE);
    end
  endtask : t_par_blank
  task t_ser_match;
    logic [7:0] b;
    logic [7:0] first;
    @(posedge ref_clk);
    cmpEqual     <= {112{2'b01}};
    parallelMode <= MODE_SERIAL;
    pointerReset <= 1'b1;
    @(posedge ref_clk);
    pointerReset <= 1'b0;
    start_read(BYTES_PER_LINE);
    get_byte(first);
    check(first, 8'h01);
    for (int i = 1; i < BYTES_PER_LINE; i++) begin
      get_byte(b);
      check(b, (i == 224) ? LINE_TERM_BYTE : (i % 2 == 0) ? 8'h01 : FULL_SCALE);
    end
  endtask : t_ser_match
  task t_dyn;
    @(posedge ref_clk);
    highDynamics <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(refSelectHigh, 8'h00);
    highDynamics <= 1'b1;
  endtask : t_dyn
  task end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_par_blank();
    t_ser_match();
    t_dyn();
    check(termMiss, 8'h00);
    end_of_test();
  end
endmodule : pixel_line_acquire_readout_test
`default_nettype wire
